// ---- rtl/psmc_pkg.sv ----
package psmc_pkg;
    // Register word addresses (byte addresses, one aligned word each)
    localparam logic [3:0] ADDR_REGULATOR = 4'h0;
    localparam logic [3:0] ADDR_SLOW_HALT = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_CONFIG = 4'hc;

    // Regulator control fields
    localparam int REG_RESERVED_BIT = 0;
    localparam int REG_LOW_POWER_BIT = 1;
    localparam logic [7:0] REGULATOR_RESET = 8'h01;
    localparam logic [7:0] REGULATOR_MASK = 8'h03;

    // Slowed-CPU and halt control fields
    localparam int SH_HALT_BIT = 7;
    localparam int SH_ACTIVE_BIT = 6;
    localparam int SH_RECOVER_BIT = 5;
    localparam int SH_EXIT_BIT = 4;
    localparam int SH_RATIO_LSB = 0;
    localparam int RATIO_W = 3;
    localparam logic [7:0] SLOW_HALT_RESET = 8'h00;
    localparam logic [7:0] SLOW_HALT_MASK = 8'hf7;

    // Config register fields: oscillator mode, brown-out disable
    localparam int CFG_CRYSTAL_BIT = 0;
    localparam int CFG_BOR_OFF_BIT = 1;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // Status register fields
    localparam int ST_POWER_DOWN_BIT = 0;
    localparam int ST_WDT_EXPIRED_BIT = 1;
    localparam int ST_STATE_LSB = 2;

    // Wake timing
    localparam int OST_OSC_PERIODS = 1024;
    localparam int REGULATOR_SETTLE_NS = 10000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int REGULATOR_SETTLE_CYC = (REGULATOR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COUNT_W = 11;

    localparam logic [15:0] ISR_VECTOR = 16'h0004;

    typedef enum logic [4:0] {
        PSMC_RUN = 5'b00001,
        PSMC_SLEEP = 5'b00010,
        PSMC_IDLE = 5'b00100,
        PSMC_WAKE_WAIT = 5'b01000,
        PSMC_RESUME = 5'b10000
    } psmc_state_t;

    // Core-side event strobes
    typedef struct packed {
        logic sleep_exec;
        logic irq_entry;
        logic irq_return;
        logic wdt_timeout;
    } psmc_core_ev_t;

    // Clock and core controls
    typedef struct packed {
        logic sys_clk_en;
        logic instr_clk_en;
        logic periph_clk_en;
        logic cpu_run_en;
        logic clkout_drive;
        logic regulator_low_power;
        logic wdt_clear;
    } psmc_ctrl_t;
endpackage

// ---- rtl/psmc_slow_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
// One active CPU cycle in every 2^(ratio+1) instruction cycles
module psmc_slow_gate #(
    parameter int RATIO_W = 3
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic instr_tick_i,
    input wire logic slow_active_i,
    input wire logic [RATIO_W-1:0] ratio_i,
    output logic cpu_slot_o
);
    localparam int CNT_W = (1 << RATIO_W) + 1;
    initial begin
        if (RATIO_W < 1 || RATIO_W > 4) begin
            $error("psmc_slow_gate: unsupported RATIO_W");
        end
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    wire [CNT_W-1:0] last_w = CNT_W'((1 << (ratio_i + 1)) - 1);
    wire wrap_w = (cnt_q >= last_w);

    assign cnt_d = wrap_w ? '0 : cnt_q + 1'b1;
    // Slot at count zero; normal mode passes every tick
    assign cpu_slot_o = instr_tick_i & (~slow_active_i | (cnt_q == '0));

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !slow_active_i) begin
            cnt_q <= '0;
        end else if (instr_tick_i) begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/psmc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Irq pending at SLEEP makes it a no-op; flags and watchdog untouched.
// - Irq during/after SLEEP: finish, wake, clear watchdog, set expired, clear power-down.
// - Clock-switch interrupt never wakes or cancels SLEEP; all others do.
// - Crystal modes wait 1024 oscillator periods on Sleep wake; others skip.
// - Irq wake with global enable and no watchdog time-out branches to vector 0004h, else continues in-line.
// - Low-power regulator bit gives low-current Sleep and a wake settle delay run alongside the crystal wait.
// - Regulator reserved bit 0 reads one, resets one; software writes one.
// - Halt select 1 makes SLEEP enter Idle, 0 enters full Sleep.
// - Any interrupt but clock-switch ends Idle regardless of global enable; halt select kept.
// - Recover-on-irq with slowed mode: Idle-ending irq restores full speed.
// - Watchdog time-out in Idle wakes, no reset, slowed bit untouched.
// - Clock output stays driven in Idle when its enable is asserted.
// - System and instruction clocks stop only in Sleep.
// - Slowed-CPU active bit selects mode; hardware may set or clear it.
// - Recover-on-irq clears slowed bit on service entry.
// - Slow-on-exit sets slowed bit on service return.
// - Ratio code 000 gives 1:2, each step doubles, 111 gives 1:256.
// - Unimplemented bits read zero.
// - Slowed mode: one active cycle then idle for rest of ratio.
// - Sleep wake waits flash, oscillator and brown-out ready.
module psmc_ctrl
    import psmc_pkg::*;
#(
    parameter int OST_CYC = OST_OSC_PERIODS,
    parameter int SETTLE_CYC = REGULATOR_SETTLE_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    input wire psmc_pkg::psmc_core_ev_t core_ev_i,
    input wire logic irq_pending_i,
    input wire logic clock_switch_irq_i,
    input wire logic global_irq_enable_i,
    input wire logic clock_output_enable_n_i,
    input wire logic program_flash_ready_i,
    input wire logic osc_ready_i,
    input wire logic bor_ready_i,
    input wire logic instr_tick_i,
    output psmc_pkg::psmc_ctrl_t ctrl_o,
    output logic cpu_slot_o,
    output logic wake_vector_o,
    output logic wake_inline_o,
    output logic [15:0] vector_addr_o,
    output logic power_down_flag_o,
    output logic watchdog_expired_flag_o
);
    import psmc_pkg::*;

    initial begin
        if (OST_CYC < 1 || OST_CYC >= (1 << COUNT_W) || SETTLE_CYC < 1 || SETTLE_CYC >= (1 << COUNT_W)) begin
            $error("psmc_ctrl: wake counts do not fit counter");
        end
    end

    logic [7:0] regulator_q;
    logic [7:0] slow_halt_q;
    logic [7:0] slow_halt_d;
    logic [7:0] config_q;
    logic power_down_flag_q;
    logic watchdog_expired_flag_q;
    psmc_state_t state_q;
    psmc_state_t state_d;
    logic [COUNT_W-1:0] wait_q;
    logic [COUNT_W-1:0] wait_d;
    logic from_irq_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    logic wake_vector_q;
    logic wake_inline_q;
    logic wdt_clear_q;

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                              input logic [3:0] be, input logic [7:0] mask);
        merge_byte = be[0] ? (wd[7:0] & mask) : old;
    endfunction

    // Bus decode; every access answers one cycle after it is seen
    wire access_w = (avs_read_i | avs_write_i) & ~ack_q;
    // Write lands only on the completing edge, where waitrequest is low
    wire wr_w = avs_write_i & ack_q;
    wire hit_reg_w = (avs_address_i == ADDR_REGULATOR);
    wire hit_sh_w = (avs_address_i == ADDR_SLOW_HALT);
    wire hit_st_w = (avs_address_i == ADDR_STATUS);
    wire hit_cfg_w = (avs_address_i == ADDR_CONFIG);
    wire mapped_w = hit_reg_w | hit_sh_w | hit_st_w | hit_cfg_w;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_readdata_o = rdata_q;
    assign avs_response_o = resp_q;

    // Wake sources; clock-switch interrupt excluded
    wire irq_wake_w = irq_pending_i & ~clock_switch_irq_i;
    wire halt_sel_w = slow_halt_q[SH_HALT_BIT];
    wire crystal_w = config_q[CFG_CRYSTAL_BIT];
    wire bor_ok_w = bor_ready_i | config_q[CFG_BOR_OFF_BIT];
    wire ready_w = program_flash_ready_i & osc_ready_i & bor_ok_w;
    wire sleep_go_w = (state_q == PSMC_RUN) & core_ev_i.sleep_exec;
    wire sleep_nop_w = sleep_go_w & irq_wake_w;
    wire sleep_take_w = sleep_go_w & ~irq_wake_w;
    wire idle_irq_w = (state_q == PSMC_IDLE) & irq_wake_w;
    wire idle_wdt_w = (state_q == PSMC_IDLE) & core_ev_i.wdt_timeout & ~irq_wake_w;
    wire sleep_wake_w = (state_q == PSMC_SLEEP) & (irq_wake_w | core_ev_i.wdt_timeout);
    wire [COUNT_W-1:0] ost_w = crystal_w ? COUNT_W'(OST_CYC) : '0;
    wire [COUNT_W-1:0] settle_w = regulator_q[REG_LOW_POWER_BIT] ? COUNT_W'(SETTLE_CYC) : '0;

    always_comb begin
        state_d = state_q;
        wait_d = wait_q;
        case (state_q)
            PSMC_RUN: begin
                if (sleep_take_w) begin
                    state_d = halt_sel_w ? PSMC_IDLE : PSMC_SLEEP;
                end
            end
            PSMC_SLEEP: begin
                if (sleep_wake_w) begin
                    state_d = PSMC_WAKE_WAIT;
                    wait_d = (ost_w > settle_w) ? ost_w : settle_w;
                end
            end
            PSMC_IDLE: begin
                if (idle_irq_w || idle_wdt_w) begin
                    state_d = PSMC_RESUME;
                end
            end
            PSMC_WAKE_WAIT: begin
                if (wait_q != '0) begin
                    wait_d = wait_q - 1'b1;
                end else if (ready_w) begin
                    state_d = PSMC_RESUME;
                end
            end
            PSMC_RESUME: begin
                state_d = PSMC_RUN;
            end
            default: begin
                state_d = PSMC_RUN;
                wait_d = '0;
            end
        endcase
    end

    // Slowed-CPU bit: software write, then hardware entry/recover/exit
    always_comb begin
        slow_halt_d = slow_halt_q;
        if (wr_w && hit_sh_w) begin
            slow_halt_d = merge_byte(slow_halt_q, avs_writedata_i, avs_byteenable_i, SLOW_HALT_MASK);
        end
        if (core_ev_i.irq_entry && slow_halt_q[SH_RECOVER_BIT]) begin
            slow_halt_d[SH_ACTIVE_BIT] = 1'b0;
        end
        if (idle_irq_w && slow_halt_q[SH_RECOVER_BIT]) begin
            slow_halt_d[SH_ACTIVE_BIT] = 1'b0;
        end
        if (core_ev_i.irq_return && slow_halt_q[SH_EXIT_BIT]) begin
            slow_halt_d[SH_ACTIVE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= PSMC_RUN;
            wait_q <= '0;
            from_irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wait_q <= wait_d;
            if (sleep_wake_w || idle_irq_w || idle_wdt_w) begin
                from_irq_q <= irq_wake_w & ~core_ev_i.wdt_timeout;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            regulator_q <= REGULATOR_RESET;
            slow_halt_q <= SLOW_HALT_RESET;
            config_q <= CONFIG_RESET;
        end else begin
            slow_halt_q <= slow_halt_d;
            if (wr_w && hit_reg_w) begin
                // Reserved bit forced high whatever software writes
                regulator_q <= merge_byte(regulator_q, avs_writedata_i, avs_byteenable_i, REGULATOR_MASK)
                    | REGULATOR_RESET;
            end
            if (wr_w && hit_cfg_w) begin
                config_q <= merge_byte(config_q, avs_writedata_i, avs_byteenable_i, 8'h03);
            end
        end
    end

    // Status flags; nop leaves both untouched, taken SLEEP updates both, watchdog wake clears only the expired flag
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            power_down_flag_q <= 1'b1;
            watchdog_expired_flag_q <= 1'b1;
            wdt_clear_q <= 1'b0;
        end else begin
            wdt_clear_q <= 1'b0;
            if (sleep_take_w) begin
                power_down_flag_q <= 1'b0;
                watchdog_expired_flag_q <= 1'b1;
                wdt_clear_q <= 1'b1;
            end else if ((sleep_wake_w || idle_wdt_w) && core_ev_i.wdt_timeout && !irq_wake_w) begin
                watchdog_expired_flag_q <= 1'b0;
                wdt_clear_q <= 1'b1;
            end else if (sleep_wake_w) begin
                wdt_clear_q <= 1'b1;
            end
        end
    end

    // Resume answer to core: vector or in-line
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wake_vector_q <= 1'b0;
            wake_inline_q <= 1'b0;
        end else begin
            wake_vector_q <= (state_q == PSMC_RESUME) & from_irq_q & global_irq_enable_i;
            wake_inline_q <= (state_q == PSMC_RESUME) & ~(from_irq_q & global_irq_enable_i);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            resp_q <= 2'b00;
        end else begin
            ack_q <= access_w;
            if (access_w) begin
                resp_q <= mapped_w ? 2'b00 : 2'b10;
                rdata_q <= '0;
                if (avs_read_i) begin
                    case (1'b1)
                        hit_reg_w: rdata_q <= {24'h000000, regulator_q};
                        hit_sh_w: rdata_q <= {24'h000000, slow_halt_q};
                        hit_cfg_w: rdata_q <= {24'h000000, config_q};
                        hit_st_w: rdata_q <= {25'h0000000, state_q, watchdog_expired_flag_q,
                                              power_down_flag_q};
                        default: rdata_q <= '0;
                    endcase
                end
            end
        end
    end

    wire in_sleep_w = (state_q == PSMC_SLEEP) | (state_q == PSMC_WAKE_WAIT);
    wire in_idle_w = (state_q == PSMC_IDLE);

    psmc_slow_gate #(
        .RATIO_W(RATIO_W)
    ) u_slow_gate (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .instr_tick_i(instr_tick_i & ~in_sleep_w & ~in_idle_w),
        .slow_active_i(slow_halt_q[SH_ACTIVE_BIT]),
        .ratio_i(slow_halt_q[SH_RATIO_LSB +: RATIO_W]),
        .cpu_slot_o(cpu_slot_o)
    );

    assign ctrl_o.sys_clk_en = ~in_sleep_w;
    assign ctrl_o.instr_clk_en = ~in_sleep_w;
    assign ctrl_o.periph_clk_en = ~in_sleep_w;
    assign ctrl_o.cpu_run_en = ~in_sleep_w & ~in_idle_w & (state_q != PSMC_RESUME);
    assign ctrl_o.clkout_drive = ~clock_output_enable_n_i & ~in_sleep_w;
    assign ctrl_o.regulator_low_power = in_sleep_w & regulator_q[REG_LOW_POWER_BIT];
    assign ctrl_o.wdt_clear = wdt_clear_q;
    assign wake_vector_o = wake_vector_q;
    assign wake_inline_o = wake_inline_q;
    assign vector_addr_o = ISR_VECTOR;
    assign power_down_flag_o = power_down_flag_q;
    assign watchdog_expired_flag_o = watchdog_expired_flag_q;
endmodule
`default_nettype wire

// ---- testbench/psmc_ctrl_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module psmc_ctrl_properties #(
    parameter int OST_CYC = 8,
    parameter int SETTLE_CYC = 3
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire psmc_pkg::psmc_core_ev_t core_ev_i,
    input wire logic irq_pending_i,
    input wire logic clock_switch_irq_i,
    input wire logic clock_output_enable_n_i,
    input wire logic instr_tick_i,
    input wire psmc_pkg::psmc_ctrl_t ctrl_o,
    input wire logic cpu_slot_o,
    input wire logic wake_vector_o,
    input wire logic wake_inline_o,
    input wire logic [15:0] vector_addr_o,
    input wire logic power_down_flag_o,
    input wire logic watchdog_expired_flag_o
);
    import psmc_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req_wait;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_sleep_nop;
        core_ev_i.sleep_exec && irq_pending_i && !clock_switch_irq_i && !core_ev_i.wdt_timeout;
    endsequence
    sequence s_sleep_go;
        core_ev_i.sleep_exec && ctrl_o.cpu_run_en && !irq_pending_i;
    endsequence
    a_wait_one: assert property (s_req_wait |=> !avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");
    a_nop_flags: assert property (s_sleep_nop |=> $stable(power_down_flag_o) &&
        $stable(watchdog_expired_flag_o) && !ctrl_o.wdt_clear ##1 !ctrl_o.wdt_clear)
        else $error("no-op sleep changed flags or watchdog");
    a_sleep_flags: assert property (s_sleep_go |=>
        !power_down_flag_o && watchdog_expired_flag_o ##[0:1] ctrl_o.wdt_clear)
        else $error("sleep entry flags or watchdog clear wrong");
    a_clear_pulse: assert property ($rose(ctrl_o.wdt_clear) |=> !ctrl_o.wdt_clear)
        else $error("watchdog clear longer than one cycle");
    a_clock_pair: assert property (ctrl_o.sys_clk_en == ctrl_o.instr_clk_en)
        else $error("system and instruction clocks disagree");
    a_sleep_halts: assert property (!ctrl_o.sys_clk_en |-> !ctrl_o.cpu_run_en && !cpu_slot_o)
        else $error("cpu runs with system clock stopped");
    a_clkout_kept: assert property (ctrl_o.sys_clk_en && !clock_output_enable_n_i |-> ctrl_o.clkout_drive)
        else $error("clock output dropped while clock runs");
    a_vector_once: assert property (wake_vector_o |-> vector_addr_o == 16'h0004 &&
        !wake_inline_o ##1 !wake_vector_o)
        else $error("vector pulse wrong");
    a_slot_tick: assert property (cpu_slot_o |-> instr_tick_i)
        else $error("cpu slot without instruction tick");
endmodule
bind psmc_ctrl psmc_ctrl_properties #(.OST_CYC(OST_CYC), .SETTLE_CYC(SETTLE_CYC)) u_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .core_ev_i(core_ev_i), .irq_pending_i(irq_pending_i),
    .clock_switch_irq_i(clock_switch_irq_i), .clock_output_enable_n_i(clock_output_enable_n_i),
    .instr_tick_i(instr_tick_i), .ctrl_o(ctrl_o), .cpu_slot_o(cpu_slot_o), .wake_vector_o(wake_vector_o),
    .wake_inline_o(wake_inline_o), .vector_addr_o(vector_addr_o), .power_down_flag_o(power_down_flag_o),
    .watchdog_expired_flag_o(watchdog_expired_flag_o));
`default_nettype wire

// ---- testbench/psmc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module psmc_core_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] cmd_i,
    input wire logic [4:0] lag_i,
    input wire logic sys_clk_en_i,
    input wire logic wake_vector_i,
    output psmc_pkg::psmc_core_ev_t core_ev_o,
    output logic ready_o
);
    import psmc_pkg::*;
    logic [4:0] stop_cnt_q;
    // Lag 0 answers at once; larger lags model a slow oscillator restart
    assign ready_o = stop_cnt_q >= lag_i;
    always_ff @(posedge core_clk_i) begin
        if (rst_i || sys_clk_en_i) begin
            stop_cnt_q <= 5'h00;
        end else if (stop_cnt_q != 5'h1f) begin
            stop_cnt_q <= stop_cnt_q + 5'h01;
        end
        // Branch to the vector is the service entry
        core_ev_o <= rst_i ? '0 : {cmd_i[3], cmd_i[2] | wake_vector_i, cmd_i[1], cmd_i[0]};
    end
endmodule
`default_nettype wire

// ---- testbench/tb_power_saving_mode_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_power_saving_mode_control;
    import psmc_pkg::*;
    localparam int OST = 8;
    localparam int SETL = 3;
    logic core_clk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, irq = 1'b0, csw = 1'b0, gbl = 1'b0;
    logic coe_n = 1'b0;
    logic [3:0] addr = 4'h0, cmd = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [1:0] resp;
    logic wait_o, rdy, slot, wvec, winl, pdf, wxf, seen_vec;
    logic [15:0] vaddr;
    psmc_core_ev_t ev;
    psmc_ctrl_t ctrl;
    int fails = 0, total_checks = 0, n, e;
    psmc_ctrl #(.OST_CYC(OST), .SETTLE_CYC(SETL)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'h1), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .avs_response_o(resp),
        .core_ev_i(ev), .irq_pending_i(irq), .clock_switch_irq_i(csw), .global_irq_enable_i(gbl),
        .clock_output_enable_n_i(coe_n), .program_flash_ready_i(rdy), .osc_ready_i(rdy), .bor_ready_i(rdy),
        .instr_tick_i(1'b1), .ctrl_o(ctrl), .cpu_slot_o(slot), .wake_vector_o(wvec), .wake_inline_o(winl),
        .vector_addr_o(vaddr), .power_down_flag_o(pdf), .watchdog_expired_flag_o(wxf));
    psmc_core_model u_core (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_i(cmd), .lag_i(5'h00),
        .sys_clk_en_i(ctrl.sys_clk_en), .wake_vector_i(wvec), .core_ev_o(ev), .ready_o(rdy));
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Slots in 512 ticks: one per 2^(code+1), every tick when not slowed
    function automatic int exp_slots(input int c);
        exp_slots = c < 8 ? 512 >> (c + 1) : 512;
    endfunction
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int k;
        k = 0;
        addr <= a;
        wdat <= {24'h0, d};
        rd <= !w;
        wr <= w;
        // Read right after the edge: these are the values that edge sampled
        do begin
            @(posedge core_clk_i);
            k++;
            if (k > 20) begin
                fails++;
                stop_test();
            end
        end while (wait_o !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic pulse(input logic [3:0] c);
        cmd <= c;
        @(posedge core_clk_i);
        cmd <= 4'h0;
        repeat (3) @(posedge core_clk_i);
    endtask
    initial begin
        void'($urandom(32'h810ce154));
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        bus(0, ADDR_REGULATOR, 8'h00);
        chk(q, 32'h01);
        bus(0, ADDR_SLOW_HALT, 8'h00);
        chk(q, 32'h00);
        bus(0, ADDR_STATUS, 8'h00);
        chk(q, 32'h07);
        bus(0, 4'h2, 8'h00);
        chk({q[31:2], resp}, 32'h2);
        for (int i = 0; i < 4; i++) begin
            e = $urandom;
            bus(1, ADDR_REGULATOR, {e[7:1], 1'b1});
            bus(0, ADDR_REGULATOR, 8'h00);
            chk(q, {30'h0, e[1], 1'b1});
            bus(1, ADDR_SLOW_HALT, e[7:0] & 8'h7f);
            bus(0, ADDR_SLOW_HALT, 8'h00);
            chk(q, {24'h0, e[7:0] & 8'h77});
        end
        $display("test registers done");
        irq <= 1'b1;
        pulse(4'h8);
        bus(0, ADDR_STATUS, 8'h00);
        chk(q, 32'h07);
        irq <= 1'b0;
        $display("test no-op sleep done");
        for (int c = 0; c < 4; c++) begin
            gbl <= c[0] ^ c[1];
            bus(1, ADDR_CONFIG, {7'h0, c[0]});
            bus(1, ADDR_REGULATOR, {6'h0, c[1], 1'b1});
            irq <= (c == 0);
            csw <= (c == 0);
            pulse(4'h8);
            bus(0, ADDR_STATUS, 8'h00);
            chk(q, 32'h0a);
            chk(32'(ctrl.sys_clk_en), 32'h0);
            chk(32'(ctrl.regulator_low_power), 32'(c[1]));
            irq <= 1'b1;
            csw <= 1'b0;
            n = 0;
            do begin
                @(negedge core_clk_i);
                n++;
            end while (!(wvec === 1'b1 || winl === 1'b1) && n < 200);
            if (n >= 200) begin
                fails++;
                stop_test();
            end
            seen_vec = wvec;
            chk(32'(winl), 32'(!(c[0] ^ c[1])));
            e = c[0] ? OST : (c[1] ? SETL : 0);
            chk(32'(n > e && n <= e + 6), 32'h1);
            chk(32'(seen_vec), 32'(c[0] ^ c[1]));
            @(posedge core_clk_i);
            irq <= 1'b0;
            repeat (3) @(posedge core_clk_i);
        end
        $display("test sleep wake done");
        gbl <= 1'b0;
        e = $urandom_range(7, 0);
        bus(1, ADDR_SLOW_HALT, 8'he0 | e[7:0]);
        pulse(4'h8);
        bus(0, ADDR_STATUS, 8'h00);
        chk(q, 32'h12);
        chk(32'({ctrl.sys_clk_en, ctrl.clkout_drive}), 32'h3);
        coe_n <= 1'b1;
        @(posedge core_clk_i);
        chk(32'(ctrl.clkout_drive), 32'h0);
        coe_n <= 1'b0;
        irq <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        irq <= 1'b0;
        bus(0, ADDR_SLOW_HALT, 8'h00);
        chk(q, 32'ha0 | e);
        bus(1, ADDR_SLOW_HALT, 8'he0 | e[7:0]);
        pulse(4'h8);
        pulse(4'h1);
        bus(0, ADDR_SLOW_HALT, 8'h00);
        chk(q, 32'he0 | e);
        bus(0, ADDR_STATUS, 8'h00);
        chk(q, 32'h04);
        $display("test idle done");
        for (int k = 0; k < 4; k++) begin
            bus(1, ADDR_SLOW_HALT, {2'b01, k[1:0], 4'h0});
            pulse(4'h4);
            bus(0, ADDR_SLOW_HALT, 8'h00);
            chk(q, {25'h0, !k[1], k[1:0], 4'h0});
            bus(1, ADDR_SLOW_HALT, {2'b00, k[1:0], 4'h0});
            pulse(4'h2);
            bus(0, ADDR_SLOW_HALT, 8'h00);
            chk(q, {25'h0, k[0], k[1:0], 4'h0});
        end
        $display("test service entry done");
        for (int c = 0; c < 9; c++) begin
            bus(1, ADDR_SLOW_HALT, c < 8 ? 8'h40 | c[7:0] : 8'h00);
            n = 0;
            repeat (512) begin
                @(negedge core_clk_i);
                n += (slot === 1'b1);
            end
            @(posedge core_clk_i);
            e = exp_slots(c);
            chk(32'(n >= e && n <= e + 1), 32'h1);
        end
        $display("test slow ratio done");
        stop_test();
    end
endmodule
`default_nettype wire
